// file: hw/wdt_map.svh
`ifndef WDT_MAP_SVH
`define WDT_MAP_SVH

// AXI4-Lite byte offsets
`define WDT_ENABLE_CONTROL_OFF 8'h00
`define WDT_STATUS_OFF 8'h04
`define WDT_COMMAND_OFF 8'h08
`define WDT_COUNT_OFF 8'h0c

// Enable control fields
`define WDT_KEY_LSB 0
`define WDT_KEY_MSB 3
`define WDT_ODE_LSB 4
`define WDT_ODE_MSB 7
`define WDT_ENABLE_CONTROL_RESET 8'h0a
`define WDT_KEY_DISABLE 4'ha
`define WDT_KEY_RECOMMENDED 4'h5

// Status fields
`define WDT_STAT_TIMEOUT_BIT 0
`define WDT_STAT_POWERDOWN_BIT 1
`define WDT_STAT_ENABLED_BIT 2

// Command fields (write-one pulses)
`define WDT_CMD_CLEAR_SINGLE_BIT 0
`define WDT_CMD_CLEAR_FIRST_BIT 1
`define WDT_CMD_CLEAR_SECOND_BIT 2
`define WDT_CMD_HALT_BIT 3
`define WDT_CMD_WAKE_BIT 4

// Divider
`define WDT_SYS_PRESCALE 4
`define WDT_DIV_MIN_LOG2 13
`define WDT_DIV_MAX_LOG2 16

`endif

// file: hw/wdt_pkg.sv
package wdt_pkg;
	typedef enum logic [1:0] {
		WDT_SRC_SUB = 2'h0,
		WDT_SRC_SYS_DIV4 = 2'h1
	} wdt_src_e;

	typedef enum logic [1:0] {
		WDT_CLR_SINGLE = 2'h0,
		WDT_CLR_PAIRED = 2'h1
	} wdt_clr_style_e;

	// Which half of a paired clear is expected next; either half may open a pair
	typedef enum logic [2:0] {
		WDT_PAIR_ANY = 3'b001,
		WDT_PAIR_WANT_SECOND = 3'b010,
		WDT_PAIR_WANT_FIRST = 3'b100
	} wdt_pair_e;

	typedef enum logic [1:0] {
		WDT_RESP_OKAY = 2'h0,
		WDT_RESP_SLVERR = 2'h2
	} wdt_resp_e;
endpackage

// file: hw/wdt_timer.sv
// Function
// - Option picks sub clock or system/4
// - Sub clock from RC or crystal oscillator
// - Option off: key decides; clear instructions are no-ops when the key disables
// - Key 1010 disables, others keep enabled
// - Key resets to 1010 at power-on
// - Option on: runs regardless of key
// - Divide source by 2^13 to 2^16
// - Software clear resets only last stage
// - System/4 source stops in power-down
// - Normal overflow: device reset, set timeout
// - Power-down overflow: set timeout, reset PC/SP
// - External reset, clear commands, HALT clear counter
// - Option picks single or paired clear style
// - Paired style needs alternating halves
// - HALT clears; sub source runs, system stops
// - HALT sets power-down, clears timeout
// - Power-down cleared by power-up or clear
`timescale 1ns/100ps
`include "wdt_map.svh"

module wdt_timer
	import wdt_pkg::*;
#(
	parameter logic CFG_WDT_ENABLE = 1'b0,
	parameter wdt_src_e CFG_SOURCE = WDT_SRC_SUB,
	parameter wdt_clr_style_e CFG_CLR_STYLE = WDT_CLR_SINGLE,
	parameter int CFG_DIV_LOG2 = `WDT_DIV_MAX_LOG2
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic external_reset_pin_n,
	input wire logic sub_clock_tick,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic device_reset,
	output logic pc_sp_reset,
	output logic [3:0] open_drain_ctrl,
	output logic powerdown
);

	localparam int CNT_W = `WDT_DIV_MAX_LOG2;

	// AXI4-Lite write path: address and data latched independently
	logic aw_held;
	logic w_held;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic wr_fire;
	logic wr_ok;

	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready = !w_held && !s_axi_bvalid;
	assign wr_fire = aw_held && w_held && !s_axi_bvalid;
	assign wr_ok = aw_addr == `WDT_ENABLE_CONTROL_OFF || aw_addr == `WDT_COMMAND_OFF;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= {s_axi_awaddr[7:2], 2'b00};
			end else if (wr_fire) begin
				aw_held <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end else if (wr_fire) begin
				w_held <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= WDT_RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_ok ? WDT_RESP_OKAY : WDT_RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Command pulses, only on a full low byte write
	logic cmd_wr;
	logic cmd_single;
	logic cmd_first;
	logic cmd_second;
	logic cmd_halt;
	logic cmd_wake;

	assign cmd_wr = wr_fire && aw_addr == `WDT_COMMAND_OFF && w_strb[0];
	assign cmd_single = cmd_wr && w_data[`WDT_CMD_CLEAR_SINGLE_BIT];
	assign cmd_first = cmd_wr && w_data[`WDT_CMD_CLEAR_FIRST_BIT];
	assign cmd_second = cmd_wr && w_data[`WDT_CMD_CLEAR_SECOND_BIT];
	assign cmd_halt = cmd_wr && w_data[`WDT_CMD_HALT_BIT];
	assign cmd_wake = cmd_wr && w_data[`WDT_CMD_WAKE_BIT];

	// Enable control register
	logic [7:0] enable_control;
	logic wdt_enabled;

	always_ff @(posedge aclk) begin
		if (!aresetn || !external_reset_pin_n) begin
			enable_control <= `WDT_ENABLE_CONTROL_RESET;
		end else if (wr_fire && aw_addr == `WDT_ENABLE_CONTROL_OFF && w_strb[0]) begin
			enable_control <= w_data[7:0];
		end
	end

	assign open_drain_ctrl = enable_control[`WDT_ODE_MSB:`WDT_ODE_LSB];
	assign wdt_enabled = CFG_WDT_ENABLE || enable_control[`WDT_KEY_MSB:`WDT_KEY_LSB] != `WDT_KEY_DISABLE;

	// Software clear decode
	wdt_pair_e pair_state;
	logic sw_clear;

	always_comb begin
		sw_clear = 1'b0;
		if (wdt_enabled) begin
			unique case (CFG_CLR_STYLE)
				WDT_CLR_SINGLE: sw_clear = cmd_single;
				WDT_CLR_PAIRED: begin
					sw_clear = (pair_state == WDT_PAIR_WANT_SECOND && cmd_second) ||
						(pair_state == WDT_PAIR_WANT_FIRST && cmd_first);
				end
				default: sw_clear = 1'b0;
			endcase
		end
	end

	// Either half arms, the other half fires; repeats of the armed half are ignored
	always_ff @(posedge aclk) begin
		if (!aresetn || !external_reset_pin_n) begin
			pair_state <= WDT_PAIR_ANY;
		end else if (wdt_enabled && CFG_CLR_STYLE == WDT_CLR_PAIRED) begin
			unique case (pair_state)
				WDT_PAIR_ANY: begin
					if (cmd_first) begin
						pair_state <= WDT_PAIR_WANT_SECOND;
					end else if (cmd_second) begin
						pair_state <= WDT_PAIR_WANT_FIRST;
					end
				end
				WDT_PAIR_WANT_SECOND: if (cmd_second) pair_state <= WDT_PAIR_ANY;
				WDT_PAIR_WANT_FIRST: if (cmd_first) pair_state <= WDT_PAIR_ANY;
				default: pair_state <= WDT_PAIR_ANY;
			endcase
		end
	end

	// Source clock enable
	logic [1:0] sys_pre;
	logic sys_tick;
	logic src_tick;
	logic halt_valid;

	assign halt_valid = cmd_halt && wdt_enabled;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sys_pre <= 2'h0;
		end else if (!powerdown) begin
			sys_pre <= sys_pre + 2'h1;
		end
	end

	assign sys_tick = !powerdown && sys_pre == 2'(`WDT_SYS_PRESCALE - 1);

	always_comb begin
		unique case (CFG_SOURCE)
			WDT_SRC_SUB: src_tick = sub_clock_tick;
			WDT_SRC_SYS_DIV4: src_tick = sys_tick;
			default: src_tick = 1'b0;
		endcase
	end

	// Divider chain; the top stage is the last bit below the selected tap
	logic [CNT_W-1:0] div_cnt;
	logic [CNT_W-1:0] next_div_cnt;
	logic overflow;

	always_comb begin
		next_div_cnt = div_cnt + CNT_W'(1);
		overflow = wdt_enabled && src_tick && (&div_cnt[CFG_DIV_LOG2-1:0]);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || !external_reset_pin_n) begin
			div_cnt <= '0;
		end else if (!wdt_enabled) begin
			div_cnt <= '0;
		end else if (halt_valid || sw_clear) begin
			// Only the last stage drops; the residual low count makes the period vary by up to half a period
			div_cnt[CFG_DIV_LOG2-1] <= 1'b0;
			div_cnt[CFG_DIV_LOG2-2:0] <= src_tick ? next_div_cnt[CFG_DIV_LOG2-2:0] : div_cnt[CFG_DIV_LOG2-2:0];
		end else if (overflow) begin
			div_cnt <= '0;
		end else if (src_tick) begin
			div_cnt <= next_div_cnt;
		end
	end

	// Flags and reset outputs
	logic timeout_flag;
	logic powerdown_flag;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			timeout_flag <= 1'b0;
		end else if (overflow) begin
			timeout_flag <= 1'b1;
		end else if (halt_valid) begin
			timeout_flag <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			powerdown_flag <= 1'b0;
		end else if (halt_valid) begin
			powerdown_flag <= 1'b1;
		end else if (sw_clear) begin
			powerdown_flag <= 1'b0;
		end
	end

	// Power-down state; wake by overflow or an explicit wake command
	always_ff @(posedge aclk) begin
		if (!aresetn || !external_reset_pin_n) begin
			powerdown <= 1'b0;
		end else if (cmd_halt) begin
			powerdown <= 1'b1;
		end else if (overflow || cmd_wake) begin
			powerdown <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			device_reset <= 1'b0;
			pc_sp_reset <= 1'b0;
		end else begin
			device_reset <= overflow && !powerdown;
			pc_sp_reset <= overflow && powerdown;
		end
	end

	// AXI4-Lite read path
	logic [31:0] rd_word;

	always_comb begin
		rd_word = 32'h0000_0000;
		unique case (s_axi_araddr[7:0] & 8'hfc)
			`WDT_ENABLE_CONTROL_OFF: rd_word = {24'h000000, enable_control};
			`WDT_STATUS_OFF: begin
				rd_word[`WDT_STAT_TIMEOUT_BIT] = timeout_flag;
				rd_word[`WDT_STAT_POWERDOWN_BIT] = powerdown_flag;
				rd_word[`WDT_STAT_ENABLED_BIT] = wdt_enabled;
			end
			`WDT_COUNT_OFF: rd_word = {16'h0000, div_cnt};
			`WDT_COMMAND_OFF: rd_word = 32'h0000_0000;
			default: rd_word = 32'h0000_0000;
		endcase
	end

	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= WDT_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_word;
			s_axi_rresp <= (s_axi_araddr[7:0] & 8'hfc) > `WDT_COUNT_OFF ? WDT_RESP_SLVERR : WDT_RESP_OKAY;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule

// file: verif/wdt_timer_properties.sv
`timescale 1ns/100ps
module wdt_checker (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic external_reset_pin_n,
	input wire logic s_axi_awready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic device_reset,
	input wire logic pc_sp_reset,
	input wire logic [3:0] open_drain_ctrl,
	input wire logic powerdown
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// A timeout must never repeat within eight cycles
	sequence s_dr_quiet;
		(!device_reset)[*8];
	endsequence
	sequence s_pr_quiet;
		(!pc_sp_reset)[*8];
	endsequence
	property p_rst;
		disable iff (1'b0) !aresetn |=> !device_reset && !pc_sp_reset && !powerdown && open_drain_ctrl == 4'h0;
	endproperty
	property p_dr_once;
		device_reset |=> s_dr_quiet;
	endproperty
	property p_pr_once;
		pc_sp_reset |=> s_pr_quiet;
	endproperty
	property p_dr_run;
		device_reset |-> !$past(powerdown) && !pc_sp_reset;
	endproperty
	property p_pr_down;
		pc_sp_reset |-> $past(powerdown);
	endproperty
	property p_ext;
		!external_reset_pin_n |=> !powerdown;
	endproperty
	property p_bhold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
	endproperty
	property p_rhold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	property p_aw_busy;
		s_axi_bvalid |-> !s_axi_awready;
	endproperty
	a_rst: assert property (p_rst) else $error("outputs not idle after reset");
	a_dr_once: assert property (p_dr_once) else $error("device reset not a single pulse");
	a_pr_once: assert property (p_pr_once) else $error("pc sp reset not a single pulse");
	a_dr_run: assert property (p_dr_run) else $error("device reset while powered down");
	a_pr_down: assert property (p_pr_down) else $error("pc sp reset outside power down");
	a_ext: assert property (p_ext) else $error("power down kept over external reset");
	a_bhold: assert property (p_bhold) else $error("bvalid dropped early");
	a_rhold: assert property (p_rhold) else $error("read answer changed early");
	a_aw_busy: assert property (p_aw_busy) else $error("write taken while response pending");
endmodule
bind wdt_timer wdt_checker u_chk (.aclk(aclk), .aresetn(aresetn), .external_reset_pin_n(external_reset_pin_n),
	.s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.device_reset(device_reset), .pc_sp_reset(pc_sp_reset), .open_drain_ctrl(open_drain_ctrl),
	.powerdown(powerdown));

// file: verif/tb_wdt_timer.sv
`timescale 1ns/100ps
module tb_wdt_timer;
	logic aclk = 1'b0, aresetn = 1'b0, ext_n = 1'b1, tick = 1'b0;
	logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata, c;
	logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, dr, pr, pd;
	logic [1:0] bresp, rresp;
	logic [3:0] ode;
	int n_fail = 0, n_checks = 0, n_dr = 0, n_pr = 0, cyc = 0, i;
	// Short divider keeps each timeout near 8k cycles
	wdt_timer #(.CFG_DIV_LOG2(13)) dut_u (.aclk(aclk), .aresetn(aresetn), .external_reset_pin_n(ext_n),
		.sub_clock_tick(tick), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .device_reset(dr), .pc_sp_reset(pr),
		.open_drain_ctrl(ode), .powerdown(pd));
	initial forever #2 aclk = ~aclk;
	task wrap_up;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (dr) n_dr <= n_dr + 1;
		if (pr) n_pr <= n_pr + 1;
		if (cyc == 60000) begin
			n_fail++;
			$display("unexpected at %0t: run hung", $time);
			wrap_up;
		end
	end
	task chk(input logic [31:0] g, e);
		n_checks++;
		if (g !== e) begin
			n_fail++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task wr(input logic [31:0] a, d, input logic [1:0] e = 2'h0);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		chk(bresp, e);
	endtask
	task rd(input logic [31:0] a, e, m = 32'hffffffff, input logic [1:0] er = 2'h0);
		araddr <= a;
		arvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		chk(rdata & m, e);
		chk(rresp, er);
	endtask
	task wait_pulse(input int n);
		for (i = 0; i < 8400 && n_dr + n_pr == n; i++) @(posedge aclk);
		@(posedge aclk);
	endtask
	task t_reset;
		chk(ode, 4'h0);
		rd(8'h00, 8'h0a);
		rd(8'h04, 8'h00);
		wr(8'h40, 8'h05, 2'h2);
		rd(8'h40, 8'h00, 32'hffffffff, 2'h2);
		$display("reset test done");
	endtask
	task t_off;
		tick <= 1'b1;
		wr(8'h08, 8'h01);
		repeat (8300) @(posedge aclk);
		chk(n_dr, 0);
		rd(8'h0c, 8'h00);
		$display("disabled test done");
	endtask
	task t_run;
		wr(8'h00, 8'hc5);
		chk(ode, 4'hc);
		rd(8'h04, 8'h04);
		wait_pulse(0);
		chk(n_dr, 1);
		rd(8'h04, 8'h05);
		$display("overflow test done");
	endtask
	task t_clr;
		repeat (4200) @(posedge aclk);
		tick <= 1'b0;
		@(posedge aclk);
		rd(8'h0c, 8'h00, 32'h0);
		c = rdata;
		chk(c[12], 1'b1);
		wr(8'h08, 8'h01);
		rd(8'h0c, c & ~32'h1000);
		$display("clear test done");
	endtask
	task t_halt;
		tick <= 1'b1;
		wr(8'h08, 8'h08);
		chk(pd, 1'b1);
		rd(8'h04, 8'h06);
		wait_pulse(1);
		chk(n_pr, 1);
		chk(n_dr, 1);
		rd(8'h04, 8'h01, 32'h1);
		wr(8'h08, 8'h01);
		rd(8'h04, 8'h00, 32'h2);
		$display("halt test done");
	endtask
	task t_ext;
		ext_n <= 1'b0;
		repeat (2) @(posedge aclk);
		ext_n <= 1'b1;
		@(posedge aclk);
		rd(8'h00, 8'h0a, 32'hf);
		chk(ode, 4'h0);
		rd(8'h0c, 8'h00);
		$display("external reset test done");
	endtask
	initial begin
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_reset;
		t_off;
		t_run;
		t_clr;
		t_halt;
		t_ext;
		wrap_up;
	end
endmodule
